// File: logic/upwin_cfg.sv
// Upstream window page-size configuration and 64-bit upstream forwarding
// Behaviour
// - Normal mode: upper codes give 512K..4M
// - Extension bit selects coarse size units
// - Coarse codes 1,2,3 give 8M,16M,32M
// - Coarse code 0, 01XX, 1XXX disable window
// - Extension bit resets cleared
// - Enable clear: forward outside downstream window three
// - Enable set: forward upstream-window hits, untranslated
// - Bits 26:22 reserved, read zero
`timescale 1ns/1ps
module upwin_cfg
  import upwin_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic req_valid,
  input wire logic [63:0] req_addr,
  input wire logic req_dac,
  output logic dec_valid,
  output logic dec_fwd_up,
  output logic [63:0] dec_addr
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  bus_state_e state_r, state_nxt;
  logic [31:0] readdata_r, readdata_nxt;
  logic [3:0] code_r, code_nxt;
  logic ext_r, ext_nxt;
  logic up64_r, up64_nxt;
  logic [63:0] up_base_r, up_base_nxt;
  logic [63:0] dn3_base_r, dn3_base_nxt;
  logic [63:0] dn3_limit_r, dn3_limit_nxt;
  logic dec_valid_r, dec_valid_nxt;
  logic dec_fwd_r, dec_fwd_nxt;
  logic [63:0] dec_addr_r, dec_addr_nxt;
  logic last_dac_r, last_dac_nxt;
  logic [4:0] size_log2;
  logic win_en;
  logic wr_go;
  logic [31:0] cfg_word;
  logic [31:0] sts_word;
  logic [31:0] rd_val;
  logic in_dn3;
  logic up_hit;

  // ----------------------------------------------------------------
  // Page size decoder
  // ----------------------------------------------------------------
  // extension selects coarse
  page_size_decode u_decode (
    .code(code_r),
    .coarse(ext_r),
    .size_log2(size_log2),
    .win_en(win_en)
  );

  // ----------------------------------------------------------------
  // Avalon-MM slave handshake
  // ----------------------------------------------------------------
  // Every access takes one wait cycle so read data comes from a flop
  assign waitrequest = (read | write) & (state_r == BUS_IDLE);
  assign wr_go = write & (state_r == BUS_ACK);
  assign readdata = readdata_r;

  // Readback words; fields outside this slice read zero
  always_comb begin
    cfg_word = 32'h0;
    cfg_word[PAGE_CODE_MSB:PAGE_CODE_LSB] = code_r;
    cfg_word[PAGE_EXT_BIT] = ext_r;
    cfg_word[UP64_EN_BIT] = up64_r;
    cfg_word[RSVD_MSB:RSVD_LSB] = 5'h00;
    sts_word = 32'h0;
    sts_word[STS_SIZE_MSB:STS_SIZE_LSB] = size_log2;
    sts_word[STS_WIN_EN_BIT] = win_en;
    sts_word[STS_LAST_FWD_BIT] = dec_fwd_r;
    sts_word[STS_LAST_DAC_BIT] = last_dac_r;
  end

  // Read mux; an unmapped address reads as zero
  always_comb begin
    unique case (address)
      OFF_PAGE_CFG: rd_val = cfg_word;
      OFF_UP_BASE_LO: rd_val = up_base_r[31:0];
      OFF_UP_BASE_HI: rd_val = up_base_r[63:32];
      OFF_DN3_BASE_LO: rd_val = dn3_base_r[31:0];
      OFF_DN3_BASE_HI: rd_val = dn3_base_r[63:32];
      OFF_DN3_LIMIT_LO: rd_val = dn3_limit_r[31:0];
      OFF_DN3_LIMIT_HI: rd_val = dn3_limit_r[63:32];
      OFF_STATUS: rd_val = sts_word;
      default: rd_val = 32'h0;
    endcase
  end

  // Bus state and read data next values
  always_comb begin
    state_nxt = state_r;
    readdata_nxt = readdata_r;
    unique case (state_r)
      BUS_IDLE: begin
        if (read | write) begin
          state_nxt = BUS_ACK;
          readdata_nxt = read ? rd_val : RDATA_RST;
        end
      end
      BUS_ACK: begin
        state_nxt = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= BUS_IDLE;
      readdata_r <= RDATA_RST;
    end else begin
      state_r <= state_nxt;
      readdata_r <= readdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Writes land on the edge that completes the transfer, one after waitrequest drops; unmapped writes drop
  always_comb begin
    logic [31:0] cfg_m;
    cfg_m = merge(cfg_word, writedata, byteenable);
    code_nxt = code_r;
    ext_nxt = ext_r;
    up64_nxt = up64_r;
    up_base_nxt = up_base_r;
    dn3_base_nxt = dn3_base_r;
    dn3_limit_nxt = dn3_limit_r;
    if (wr_go) begin
      unique case (address)
        OFF_PAGE_CFG: begin
          code_nxt = cfg_m[PAGE_CODE_MSB:PAGE_CODE_LSB];
          ext_nxt = cfg_m[PAGE_EXT_BIT];
          up64_nxt = cfg_m[UP64_EN_BIT];
        end
        OFF_UP_BASE_LO: up_base_nxt[31:0] = merge(up_base_r[31:0], writedata, byteenable);
        OFF_UP_BASE_HI: up_base_nxt[63:32] = merge(up_base_r[63:32], writedata, byteenable);
        OFF_DN3_BASE_LO: dn3_base_nxt[31:0] = merge(dn3_base_r[31:0], writedata, byteenable);
        OFF_DN3_BASE_HI: dn3_base_nxt[63:32] = merge(dn3_base_r[63:32], writedata, byteenable);
        OFF_DN3_LIMIT_LO: begin
          dn3_limit_nxt[31:0] = merge(dn3_limit_r[31:0], writedata, byteenable);
        end
        OFF_DN3_LIMIT_HI: begin
          dn3_limit_nxt[63:32] = merge(dn3_limit_r[63:32], writedata, byteenable);
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      code_r <= PAGE_CODE_RST;
      ext_r <= PAGE_EXT_RST;
      up64_r <= UP64_EN_RST;
      up_base_r <= ADDR64_RST;
      dn3_base_r <= ADDR64_RST;
      dn3_limit_r <= ADDR64_RST;
    end else begin
      code_r <= code_nxt;
      ext_r <= ext_nxt;
      up64_r <= up64_nxt;
      up_base_r <= up_base_nxt;
      dn3_base_r <= dn3_base_nxt;
      dn3_limit_r <= dn3_limit_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Upstream forwarding decision
  // ----------------------------------------------------------------
  // hit sized by page
  assign up_hit = win_en & (((req_addr ^ up_base_r) >> size_log2) == 64'h0);
  assign in_dn3 = (req_addr >= dn3_base_r) & (req_addr <= dn3_limit_r);

  // Single-address requests are left to the rest of the bridge
  always_comb begin
    dec_valid_nxt = req_valid;
    dec_fwd_nxt = dec_fwd_r;
    dec_addr_nxt = dec_addr_r;
    last_dac_nxt = last_dac_r;
    if (req_valid) begin
      last_dac_nxt = req_dac;
      dec_addr_nxt = req_addr;
      if (!req_dac) begin
        dec_fwd_nxt = 1'b0;
      end else if (up64_r) begin
        dec_fwd_nxt = up_hit;
      end else begin
        dec_fwd_nxt = ~in_dn3;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dec_valid_r <= 1'b0;
      dec_fwd_r <= 1'b0;
      dec_addr_r <= ADDR64_RST;
      last_dac_r <= 1'b0;
    end else begin
      dec_valid_r <= dec_valid_nxt;
      dec_fwd_r <= dec_fwd_nxt;
      dec_addr_r <= dec_addr_nxt;
      last_dac_r <= last_dac_nxt;
    end
  end

  assign dec_valid = dec_valid_r;
  assign dec_fwd_up = dec_fwd_r;
  assign dec_addr = dec_addr_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_normal_upper_size: assert property (
    @(posedge clk) disable iff (!nrst)
    (!ext_r && code_r >= 4'hC) |-> (win_en && size_log2 == {1'b0, code_r} + 5'h07))
    else $error("normal upper page size decoded wrong");

  a_coarse_units: assert property (
    @(posedge clk) disable iff (!nrst)
    (ext_r && win_en) |-> (size_log2 >= 5'h17 && size_log2 <= 5'h19))
    else $error("coarse mode size outside coarse units");

  a_coarse_sizes: assert property (
    @(posedge clk) disable iff (!nrst)
    (ext_r && code_r == 4'h2) |-> (win_en && size_log2 == 5'h18))
    else $error("coarse code 0010 not 16M");

  a_coarse_disable: assert property (
    @(posedge clk) disable iff (!nrst)
    (ext_r && (code_r == 4'h0 || code_r[3:2] != 2'b00)) |-> !win_en)
    else $error("coarse disable code left window enabled");

  a_ext_reset_clear: assert property (
    @(posedge clk)
    $rose(nrst) |-> (!ext_r && !up64_r))
    else $error("extension or enable not cleared by reset");

  a_outside_dn3_fwd: assert property (
    @(posedge clk) disable iff (!nrst)
    (req_valid && req_dac && !up64_r && req_addr > dn3_limit_r) |=> (dec_valid && dec_fwd_up))
    else $error("64-bit request outside window three not forwarded");

  a_up64_hit_fwd: assert property (
    @(posedge clk) disable iff (!nrst)
    (req_valid && req_dac && up64_r) |=>
      (dec_fwd_up == $past(up_hit) && dec_addr == $past(req_addr)))
    else $error("64-bit upstream window decision or address wrong");

  // Readback must carry the live fields next to the zero reserved span
  a_reserved_zero: assert property (
    @(posedge clk) disable iff (!nrst)
    (read && state_r == BUS_IDLE && address == OFF_PAGE_CFG) |=>
      (!waitrequest && readdata[26:22] == 5'h00 &&
       readdata[21:16] == {$past(up64_r), $past(ext_r), $past(code_r)}))
    else $error("reserved bits read nonzero or fields lost");

  a_hit_by_size: assert property (
    @(posedge clk) disable iff (!nrst)
    (up_hit && size_log2 == 5'h17) |-> (req_addr[63:23] == up_base_r[63:23]))
    else $error("window hit ignores decoded 8M size");

endmodule

// File: logic/upwin_pkg.sv
// Shared constants for the upstream window page-size configuration block
package upwin_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_PAGE_CFG = 8'h00;
  localparam logic [7:0] OFF_UP_BASE_LO = 8'h04;
  localparam logic [7:0] OFF_UP_BASE_HI = 8'h08;
  localparam logic [7:0] OFF_DN3_BASE_LO = 8'h0C;
  localparam logic [7:0] OFF_DN3_BASE_HI = 8'h10;
  localparam logic [7:0] OFF_DN3_LIMIT_LO = 8'h14;
  localparam logic [7:0] OFF_DN3_LIMIT_HI = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;

  // ----------------------------------------------------------------
  // Page configuration field positions
  // ----------------------------------------------------------------
  localparam int PAGE_CODE_LSB = 16;
  localparam int PAGE_CODE_MSB = 19;
  localparam int PAGE_EXT_BIT = 20;
  localparam int UP64_EN_BIT = 21;
  localparam int RSVD_LSB = 22;
  localparam int RSVD_MSB = 26;

  // ----------------------------------------------------------------
  // Status field positions
  // ----------------------------------------------------------------
  localparam int STS_SIZE_LSB = 0;
  localparam int STS_SIZE_MSB = 4;
  localparam int STS_WIN_EN_BIT = 8;
  localparam int STS_LAST_FWD_BIT = 16;
  localparam int STS_LAST_DAC_BIT = 17;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] PAGE_CODE_RST = 4'h0;
  localparam logic PAGE_EXT_RST = 1'b0;
  localparam logic UP64_EN_RST = 1'b0;
  localparam logic [63:0] ADDR64_RST = 64'h0;
  localparam logic [31:0] RDATA_RST = 32'h0;

  // ----------------------------------------------------------------
  // Page size decoding: log2 of bytes = code + bias
  // ----------------------------------------------------------------
  localparam logic [4:0] NORMAL_LOG2_BIAS = 5'h07;
  localparam logic [4:0] COARSE_LOG2_BIAS = 5'h16;
  localparam logic [3:0] COARSE_MAX_CODE = 4'h3;

  // Bus handshake states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bus_state_e;

endpackage

// File: logic/page_size_decode.sv
// Page-size code decoder for the upstream memory window
`timescale 1ns/1ps
module page_size_decode
  import upwin_pkg::*;
(
  input wire logic [3:0] code,
  input wire logic coarse,
  output logic [4:0] size_log2,
  output logic win_en
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Normal codes scale by two per step from 256 bytes; coarse codes
  // start at 8M and only codes 1 to 3 are usable
  always_comb begin
    size_log2 = 5'h00;
    win_en = 1'b0;
    if (coarse) begin
      if (code != 4'h0 && code <= COARSE_MAX_CODE) begin
        size_log2 = {1'b0, code} + COARSE_LOG2_BIAS;
        win_en = 1'b1;
      end
    end else if (code != 4'h0) begin
      size_log2 = {1'b0, code} + NORMAL_LOG2_BIAS;
      win_en = 1'b1;
    end
  end

endmodule

// File: verification/initiator_model.sv
// Secondary-side initiator model issuing single-cycle memory requests
`timescale 1ns/1ps
module initiator_model (
  input wire logic clk,
  output logic req_valid,
  output logic [63:0] req_addr,
  output logic req_dac
);
  // Idle bus parks the address on a pattern, never on zero
  initial begin
    req_valid = 1'b0;
    req_addr = 64'hA5A5_A5A5_A5A5_A5A5;
    req_dac = 1'b0;
  end

  // One request after gap idle cycles; on release the lines show the inverse
  // of the last value so a stale address cannot pass for a live one
  task automatic issue(input logic [63:0] a, input logic dac, input int gap);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    req_valid <= 1'b1;
    req_addr <= a;
    req_dac <= dac;
    @(posedge clk);
    req_valid <= 1'b0;
    req_addr <= ~a;
    req_dac <= ~dac;
  endtask
endmodule

// File: verification/upstream_window_size_config_tb.sv
// Self-checking bench for the upstream window page-size configuration block
`timescale 1ns/1ps
module upstream_window_size_config_tb;
  import upwin_pkg::*;
  logic clk, nrst, read, write, waitrequest, req_valid, req_dac, dec_valid, dec_fwd_up;
  logic [7:0] address;
  logic [31:0] writedata, readdata, q;
  logic [3:0] byteenable;
  logic [63:0] req_addr, dec_addr;
  int fail_count = 0;
  int check_count = 0;
  logic en;

  upwin_cfg DUT (.clk(clk), .nrst(nrst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .req_valid(req_valid), .req_addr(req_addr),
    .req_dac(req_dac), .dec_valid(dec_valid), .dec_fwd_up(dec_fwd_up), .dec_addr(dec_addr));
  initiator_model partner (.clk(clk), .req_valid(req_valid), .req_addr(req_addr),
    .req_dac(req_dac));

  // ----------------------------------------------------------------
  // Clock, verdict and helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic summarize();
    if (fail_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Avalon transfer: held until waitrequest is sampled low, no fixed latency
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int n;
    @(posedge clk);
    address <= a;
    writedata <= d;
    byteenable <= be;
    if (wr) write <= 1'b1;
    else read <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) check(1'b1, 1'b0, "bus answer missing");
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    bus(1'b0, a, 32'h0000_0000, 4'hF);
    check(q & m, exp, "register read");
  endtask

  // One request, then its one-cycle result pulse and the held decision
  task automatic fwd(input logic [63:0] a, input logic dac, input logic exp, input int gap);
    partner.issue(a, dac, gap);
    #1;
    check(dec_valid, 1'b1, "result pulse");
    check(dec_fwd_up, exp, "forward decision");
    check(dec_addr, a, "forwarded address");
    @(posedge clk);
    #1;
    check(dec_valid, 1'b0, "result pulse end");
  endtask

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #200000;
    fail_count++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 8'h00;
    writedata = 32'h0000_0000;
    byteenable = 4'h0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    rd_chk(OFF_PAGE_CFG, 32'h0000_0000, 32'hFFFF_FFFF);
    bus(1'b1, OFF_PAGE_CFG, 32'hFFFF_FFFF, 4'hB);
    rd_chk(OFF_PAGE_CFG, 32'h0000_0000, 32'hFFFF_FFFF);
    bus(1'b1, OFF_PAGE_CFG, 32'hFFFF_FFFF, 4'hF);
    rd_chk(OFF_PAGE_CFG, 32'h003F_0000, 32'hFFFF_FFFF);
    bus(1'b1, 8'h20, 32'hFFFF_FFFF, 4'hF);
    rd_chk(8'h20, 32'h0000_0000, 32'hFFFF_FFFF);
    // Normal sizes for the upper codes: 2^(code+7) bytes
    for (int c = 12; c < 16; c++) begin
      bus(1'b1, OFF_PAGE_CFG, 32'(c) << 16, 4'hF);
      rd_chk(OFF_STATUS, {23'h0, 1'b1, 3'h0, 5'(c + 7)}, 32'h0000_011F);
    end
    // Coarse sizes: codes 1..3 give 8M..32M, all others disable the window
    for (int c = 0; c < 16; c++) begin
      bus(1'b1, OFF_PAGE_CFG, 32'h0010_0000 | (32'(c) << 16), 4'hF);
      en = (c >= 1 && c <= 3);
      rd_chk(OFF_STATUS, en ? {23'h0, 1'b1, 3'h0, 5'(c + 22)} : 32'h0,
             en ? 32'h0000_011F : 32'h0000_0100);
    end
    // Downstream window three spans 1_0000_0000 .. 1_0FFF_FFFF
    bus(1'b1, OFF_PAGE_CFG, 32'h0000_0000, 4'hF);
    bus(1'b1, OFF_DN3_BASE_HI, 32'h0000_0001, 4'hF);
    bus(1'b1, OFF_DN3_LIMIT_LO, 32'h0FFF_FFFF, 4'hF);
    bus(1'b1, OFF_DN3_LIMIT_HI, 32'h0000_0001, 4'hF);
    bus(1'b1, OFF_UP_BASE_HI, 32'h0000_0002, 4'hF);
    rd_chk(OFF_UP_BASE_HI, 32'h0000_0002, 32'hFFFF_FFFF);
    // Lane merge: only the two low lanes land, all below the smallest window size tested (512K)
    bus(1'b1, OFF_UP_BASE_LO, 32'hFFFF_FFFF, 4'h3);
    rd_chk(OFF_UP_BASE_LO, 32'h0000_FFFF, 32'hFFFF_FFFF);
    fwd(64'h1_0000_0000, 1'b1, 1'b0, 0);
    fwd(64'h1_0FFF_FFFF, 1'b1, 1'b0, 3);
    fwd(64'h1_1000_0000, 1'b1, 1'b1, 0);
    fwd(64'h0_FFFF_FFFF, 1'b1, 1'b1, 0);
    // Status keeps the last decision and the last request kind
    rd_chk(OFF_STATUS, 32'h0003_0000, 32'h0003_0000);
    fwd(64'h5_0000_0000, 1'b0, 1'b0, 0);
    rd_chk(OFF_STATUS, 32'h0000_0000, 32'h0003_0000);
    // Enable set, coarse 8M window at 2_0000_0000
    bus(1'b1, OFF_PAGE_CFG, 32'h0031_0000, 4'hF);
    rd_chk(OFF_STATUS, 32'h0000_0117, 32'h0000_011F);
    fwd(64'h2_007F_FFFF, 1'b1, 1'b1, 0);
    fwd(64'h2_0080_0000, 1'b1, 1'b0, 0);
    fwd(64'h5_0000_0000, 1'b1, 1'b0, 2);
    fwd(64'h1_0000_0000, 1'b1, 1'b0, 0);
    bus(1'b1, OFF_PAGE_CFG, 32'h002C_0000, 4'hF);
    fwd(64'h2_0007_FFFF, 1'b1, 1'b1, 0);
    fwd(64'h2_0008_0000, 1'b1, 1'b0, 0);
    bus(1'b1, OFF_PAGE_CFG, 32'h0034_0000, 4'hF);
    fwd(64'h2_0000_0000, 1'b1, 1'b0, 0);
    // Second reset in mid-run clears extension and enable again
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd_chk(OFF_PAGE_CFG, 32'h0000_0000, 32'hFFFF_FFFF);
    summarize();
  end
endmodule
